// [flk_pkg.sv]
// package: constants and carrier types for the flash block lock control
package flk_pkg;
  localparam int unsigned BLK_AW   = 5;             // block index width
  localparam int unsigned NBLK     = 32;            // number of blocks
  localparam int unsigned ADDR_W   = 16;            // word address width
  localparam int unsigned OFS_W    = 11;            // offset bits within block
  localparam logic [7:0] CMD_SETUP = 8'h60;
  localparam logic [7:0] CMD_CLR   = 8'hd0;
  localparam logic [7:0] CMD_LOCK  = 8'h01;
  localparam logic [7:0] CMD_LDOWN = 8'h2f;
  localparam logic [7:0] CMD_ID    = 8'h90;
  localparam logic [7:0] CMD_ARRAY = 8'hff;
  localparam logic [7:0] CMD_STAT  = 8'h70;
  localparam logic [7:0] CMD_CLRST = 8'h50;
  localparam logic [10:0] LOCK_OFS = 11'h002;       // identifier lock word
  localparam logic [2:0] ST_RST    = 3'h1;          // lock=1 ldn=0 hist=0
  localparam int unsigned SR_SEQ   = 5;             // status bit positions
  localparam int unsigned SR_PRG   = 4;
  localparam int unsigned SR_RDY   = 7;

  // per-block volatile state
  typedef struct packed {
    logic hist;   // was [110] before entering locked-down
    logic ldn;    // lock-down bit
    logic lock;   // lock bit
  } flk_blk_t;

  // one host write, already synchronised
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } flk_wr_t;

  typedef enum logic [1:0] {RD_ARRAY, RD_STATUS, RD_ID} flk_rmode_t;
endpackage

// [flk_blk_mem.sv]
// module: per-block lock state store, registered read port
`timescale 1ns/1ps
module flk_blk_mem
(
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  input  wire logic                     we,
  input  wire logic [flk_pkg::BLK_AW-1:0] waddr,
  input  wire flk_pkg::flk_blk_t        wdata,
  input  wire logic                     wp_fall,
  input  wire logic                     wp_rise,
  input  wire logic [flk_pkg::BLK_AW-1:0] raddr,
  output flk_pkg::flk_blk_t             rdata,
  output flk_pkg::flk_blk_t             cdata
);
  localparam int unsigned BW = flk_pkg::BLK_AW;

  flk_pkg::flk_blk_t mem_ff [flk_pkg::NBLK];

  // combinational view of the commanded block
  assign cdata = mem_ff[waddr];

  // pin edges act on all locked-down blocks at once; commands on one
  genvar g;
  generate
    for (g = 0; g < flk_pkg::NBLK; g++)
    begin : g_blk
      localparam logic [BW-1:0] IDX = BW'(g);
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          mem_ff[g] <= flk_pkg::ST_RST;  // locked, not down
        else if (wp_fall && mem_ff[g].ldn)
          mem_ff[g] <= '{hist: ~mem_ff[g].lock, ldn: 1'b1, lock: 1'b1};
        else if (wp_rise && mem_ff[g].ldn)
          mem_ff[g] <= '{hist: 1'b0, ldn: 1'b1, lock: ~mem_ff[g].hist};
        else if (we && waddr == IDX)
          mem_ff[g] <= wdata;
      end
    end
  endgenerate

  // registered read data
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= flk_pkg::ST_RST;
    else
      rdata <= mem_ff[raddr];
  end
endmodule // flk_blk_mem

// [flk_lock_ctrl.sv]
// module: block lock command decoder, status and identifier read path
`timescale 1ns/1ps
module flk_lock_ctrl
(
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       wr_stb,
  input  wire flk_pkg::flk_wr_t           wr,
  input  wire logic [flk_pkg::ADDR_W-1:0] rd_addr,
  input  wire logic                       wp_pin,
  input  wire logic                       engine_busy,
  input  wire logic                       erase_chk,
  output logic [15:0]                     rd_data,
  output logic                            rd_array,
  output logic                            erase_allowed,
  output logic                            sequence_error_flag,
  output logic                            program_error_flag
);
  localparam int unsigned AW = flk_pkg::ADDR_W;
  localparam int unsigned BW = flk_pkg::BLK_AW;

  // block index of an address
  function automatic logic [BW-1:0] blk_of(input logic [AW-1:0] a);
    blk_of = a[AW-1:flk_pkg::OFS_W];
  endfunction

  // protect pin comes from outside: two flops before use
  logic wp_s1_ff, wp_s2_ff, wp_d_ff;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_s1_ff <= 1'b0;
      wp_s2_ff <= 1'b0;
      wp_d_ff  <= 1'b0;
    end
    else
    begin
      wp_s1_ff <= wp_pin;
      wp_s2_ff <= wp_s1_ff;
      wp_d_ff  <= wp_s2_ff;
    end
  end
  // edges count only once the delay flop holds a real pin sample, so a
  // pin already high at reset is not taken for a rise
  logic [2:0] wp_vld_ff;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wp_vld_ff <= 3'h0;
    else
      wp_vld_ff <= {wp_vld_ff[1:0], 1'b1};
  end
  wire wp_fall = wp_vld_ff[2] & wp_d_ff & ~wp_s2_ff;
  wire wp_rise = wp_vld_ff[2] & ~wp_d_ff & wp_s2_ff;

  // command state
  logic                    setup_ff;
  logic [BW-1:0]           sblk_ff;
  flk_pkg::flk_rmode_t     mode_ff, nxt_mode;
  logic                    seq_ff, prg_ff;

  wire [7:0]    cd      = wr.data;
  wire [BW-1:0] wblk    = blk_of(wr.addr);
  wire          is_conf = (cd == flk_pkg::CMD_CLR) ||
                          (cd == flk_pkg::CMD_LOCK) ||
                          (cd == flk_pkg::CMD_LDOWN);
  // second write after setup: good only with confirm code in same block
  wire second   = wr_stb & setup_ff;
  wire good_seq = second & is_conf & (wblk == sblk_ff);
  wire bad_seq  = second & ~good_seq;
  wire clr_st   = wr_stb & ~setup_ff & (cd == flk_pkg::CMD_CLRST);

  // current state of the addressed block
  flk_pkg::flk_blk_t cur, upd;
  flk_pkg::flk_blk_t rdq;
  wire guard = cur.ldn & ~wp_s2_ff;  // pin low freezes locked-down
  // next block value for a good confirm; lock-down never cleared
  always_comb
  begin
    upd = cur;
    if (!guard)
    begin
      if (cd == flk_pkg::CMD_CLR)
        upd.lock = 1'b0;
      else if (cd == flk_pkg::CMD_LOCK)
        upd.lock = 1'b1;
      else
      begin
        upd.ldn  = 1'b1;
        upd.lock = 1'b1;
        upd.hist = 1'b0;
      end
    end
  end
  // supply level is not consulted for any lock command
  wire mem_we = good_seq & ~guard;

  flk_blk_mem i_flk_blk_mem
  (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .we      (mem_we),
    .waddr   (wblk),                           // good confirm: same block
    .wdata   (upd),
    .wp_fall (wp_fall),
    .wp_rise (wp_rise),
    .raddr   (blk_of(rd_addr)),
    .rdata   (rdq),
    .cdata   (cur)
  );

  // read mode selection from single-cycle commands
  always_comb
  begin
    nxt_mode = mode_ff;
    if (second)
      nxt_mode = flk_pkg::RD_STATUS;
    else if (wr_stb && cd == flk_pkg::CMD_SETUP)
      nxt_mode = flk_pkg::RD_STATUS;
    else if (wr_stb && cd == flk_pkg::CMD_ARRAY)
      nxt_mode = flk_pkg::RD_ARRAY;
    else if (wr_stb && cd == flk_pkg::CMD_ID)
      nxt_mode = flk_pkg::RD_ID;
    else if (wr_stb && cd == flk_pkg::CMD_STAT)
      nxt_mode = flk_pkg::RD_STATUS;
  end

  // command sequencer and sticky error flags; set wins over clear
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setup_ff <= 1'b0;
      sblk_ff  <= '0;
      mode_ff  <= flk_pkg::RD_ARRAY;
      seq_ff   <= 1'b0;
      prg_ff   <= 1'b0;
    end
    else
    begin
      setup_ff <= wr_stb ? (~setup_ff & (cd == flk_pkg::CMD_SETUP))
                         : setup_ff;
      if (wr_stb && !setup_ff)
        sblk_ff <= wblk;
      mode_ff <= nxt_mode;
      seq_ff  <= bad_seq | (seq_ff & ~clr_st);
      prg_ff  <= bad_seq | (prg_ff & ~clr_st);
    end
  end

  // read path; read address offset delayed to match registered rdq
  logic [flk_pkg::OFS_W-1:0] rofs_ff;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rofs_ff <= '0;
    else
      rofs_ff <= rd_addr[flk_pkg::OFS_W-1:0];
  end
  wire [15:0] sr_word = {8'h00, ~engine_busy, 1'b0, seq_ff, prg_ff, 4'h0};
  wire        id_hit  = (rofs_ff == flk_pkg::LOCK_OFS);
  wire [15:0] id_word = id_hit ? {14'h0000, rdq.ldn, rdq.lock}
                               : 16'h0000;
  wire [15:0] nxt_rd  = (mode_ff == flk_pkg::RD_STATUS) ? sr_word :
                        (mode_ff == flk_pkg::RD_ID)     ? id_word :
                                                          16'h0000;
  // registered data output
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 16'h0000;
    else
      rd_data <= nxt_rd;
  end

  assign rd_array = (mode_ff == flk_pkg::RD_ARRAY);
  // erase gate: lock bit alone decides; with the pin high a locked-down block can have lock clear
  assign erase_allowed = erase_chk & ~cur.lock;
  assign sequence_error_flag = seq_ff;
  assign program_error_flag  = prg_ff;

  // assertions
  property p_bad_sets;
    @(posedge mclk) disable iff (!rst_n)
      bad_seq |=> seq_ff && prg_ff;
  endproperty
  a_bad_sets: assert property (p_bad_sets)
    else $error("bad sequence did not set both errors");

  property p_bad_nochange;
    @(posedge mclk) disable iff (!rst_n)
      bad_seq && !wp_fall && !wp_rise
      |=> $stable(i_flk_blk_mem.mem_ff[sblk_ff]);
  endproperty
  a_bad_nochange: assert property (p_bad_nochange)
    else $error("bad sequence changed a block");

  property p_sticky;
    @(posedge mclk) disable iff (!rst_n)
      seq_ff && !clr_st |=> seq_ff;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("sequence error dropped without clear");

  property p_clear;
    @(posedge mclk) disable iff (!rst_n)
      good_seq && cd == flk_pkg::CMD_CLR && !guard && !wp_fall && !wp_rise
      |=> !i_flk_blk_mem.mem_ff[sblk_ff].lock;
  endproperty
  a_clear: assert property (p_clear)
    else $error("lock clear did not take effect");

  property p_lock;
    @(posedge mclk) disable iff (!rst_n)
      good_seq && cd == flk_pkg::CMD_LOCK && !guard && !wp_fall && !wp_rise
      |=> i_flk_blk_mem.mem_ff[sblk_ff].lock;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock set did not take effect");

  property p_ldown;
    @(posedge mclk) disable iff (!rst_n)
      good_seq && cd == flk_pkg::CMD_LDOWN && !wp_fall && !wp_rise
      |=> i_flk_blk_mem.mem_ff[sblk_ff].ldn &&
          i_flk_blk_mem.mem_ff[sblk_ff].lock;
  endproperty
  a_ldown: assert property (p_ldown)
    else $error("lock-down did not set both bits");

  property p_guard;
    @(posedge mclk) disable iff (!rst_n)
      good_seq && guard && !wp_fall && !wp_rise
      |=> $stable(i_flk_blk_mem.mem_ff[sblk_ff]);
  endproperty
  a_guard: assert property (p_guard)
    else $error("locked-down block changed while pin low");

  property p_status;
    @(posedge mclk) disable iff (!rst_n)
      second |=> mode_ff == flk_pkg::RD_STATUS;
  endproperty
  a_status: assert property (p_status)
    else $error("read mode not status after lock command");

  property p_array;
    @(posedge mclk) disable iff (!rst_n)
      wr_stb && !setup_ff && cd == flk_pkg::CMD_ARRAY |=> rd_array;
  endproperty
  a_array: assert property (p_array)
    else $error("ffh did not restore array read");

  property p_erase;
    @(posedge mclk) disable iff (!rst_n)
      erase_chk && i_flk_blk_mem.mem_ff[wblk].lock |-> !erase_allowed;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase allowed on locked block");

  property p_erase_open;
    @(posedge mclk) disable iff (!rst_n)
      erase_chk && !i_flk_blk_mem.mem_ff[wblk].lock |-> erase_allowed;
  endproperty
  a_erase_open: assert property (p_erase_open)
    else $error("erase refused on unlocked block");

  // per-block pin-edge and lock-down checks
  genvar gb;
  generate
    for (gb = 0; gb < flk_pkg::NBLK; gb++)
    begin : g_chk
      property p_fall;
        @(posedge mclk) disable iff (!rst_n)
          wp_fall && i_flk_blk_mem.mem_ff[gb].ldn
          |=> i_flk_blk_mem.mem_ff[gb].lock;
      endproperty
      a_fall: assert property (p_fall)
        else $error("pin fall left a locked-down block open");

      property p_rise;
        @(posedge mclk) disable iff (!rst_n)
          wp_rise && i_flk_blk_mem.mem_ff[gb].ldn &&
          i_flk_blk_mem.mem_ff[gb].hist
          |=> !i_flk_blk_mem.mem_ff[gb].lock;
      endproperty
      a_rise: assert property (p_rise)
        else $error("pin rise kept a block locked that was open");

      property p_ldn_kept;
        @(posedge mclk) disable iff (!rst_n)
          i_flk_blk_mem.mem_ff[gb].ldn |=> i_flk_blk_mem.mem_ff[gb].ldn;
      endproperty
      a_ldn_kept: assert property (p_ldn_kept)
        else $error("lock-down bit dropped without reset");
    end
  endgenerate

  c_bad: cover property (@(posedge mclk) disable iff (!rst_n) bad_seq);
  c_clr: cover property (@(posedge mclk) disable iff (!rst_n)
    good_seq && cd == flk_pkg::CMD_CLR);
  c_ldn: cover property (@(posedge mclk) disable iff (!rst_n)
    good_seq && cd == flk_pkg::CMD_LDOWN);
  c_fall: cover property (@(posedge mclk) disable iff (!rst_n) wp_fall);
endmodule // flk_lock_ctrl

// [flk_host.sv]
// host model: issues one-cycle command writes to the lock control
`timescale 1ns/1ps
module flk_host
(
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [7:0]  cmd,
  input  wire logic [15:0] addr,
  output logic             wr_stb,
  output flk_pkg::flk_wr_t wr
);
  // quiet bus at time zero, before the first request
  initial
  begin
    wr_stb = 1'b0;
    wr     = '0;
  end

  // strobe follows go one cycle later; idle data flips each cycle, so the stale code returns every second cycle
  always @(posedge mclk)
  begin
    wr_stb  <= go;
    wr.addr <= addr;
    wr.data <= go ? cmd : ~wr.data;
  end
endmodule // flk_host

// [test_flk_lock_ctrl.sv]
// testbench: lock commands, protect pin and identifier reads
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_flk_lock_ctrl;
  typedef struct {logic [19:0] m; logic [19:0] e; string n;} flk_exp_t;
  logic             mclk = 0, rst_n = 0, go = 0, rd_ev = 0;
  logic             wp_pin = 0, engine_busy = 0, erase_chk = 0;
  logic [7:0]       cmd = 0;
  logic [15:0]      addr = 0, rd_addr = 0, rd_data;
  logic             wr_stb, rd_array, erase_allowed, seq_f, prg_f;
  flk_pkg::flk_wr_t wr;
  int               mismatches = 0, n_checks = 0, seed = 82;
  flk_exp_t         q[$];
  wire [19:0]       obs = {rd_array, erase_allowed, seq_f, prg_f, rd_data};

  always #25 mclk = ~mclk;

  flk_host i_flk_host (.mclk(mclk), .go(go), .cmd(cmd), .addr(addr),
    .wr_stb(wr_stb), .wr(wr));
  flk_lock_ctrl i_flk_lock_ctrl (.mclk(mclk), .rst_n(rst_n),
    .wr_stb(wr_stb), .wr(wr), .rd_addr(rd_addr), .wp_pin(wp_pin),
    .engine_busy(engine_busy), .erase_chk(erase_chk), .rd_data(rd_data),
    .rd_array(rd_array), .erase_allowed(erase_allowed),
    .sequence_error_flag(seq_f), .program_error_flag(prg_f));

  // monitor: oldest note against the settled outputs, mid-cycle
  always @(negedge mclk)
    if (rd_ev === 1'b1)
    begin
      flk_exp_t x;
      x = q.pop_front();
      `CHK(x.n, x.e & x.m, obs & x.m)
      $display("test %s done", x.n);
    end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmd1(input logic [7:0] c, input logic [15:0] a);
    cmd  <= c;
    addr <= a;
    go   <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // two cycles of settling cover the registered id path
  task automatic rd(input logic [15:0] a, input logic [19:0] m, e,
                    input string n);
    rd_addr <= a;
    repeat (2) @(posedge mclk);
    q.push_back('{m, e, n});
    rd_ev <= 1'b1;
    @(posedge mclk);
    rd_ev <= 1'b0;
  endtask

  task automatic lk(input logic [7:0] c, input logic [4:0] b);
    cmd1(flk_pkg::CMD_SETUP, {b, 11'h000});
    cmd1(c, {b, 11'h000});
  endtask

  task automatic id(input logic [4:0] b, input logic d, l, input string n);
    cmd1(flk_pkg::CMD_ID, {b, 11'h000});
    rd({b, flk_pkg::LOCK_OFS}, 20'h00003, {18'h0, d, l}, n);
  endtask

  // busy level is random; ready bit must show its inverse
  task automatic st(input logic f, input string n);
    logic bz;
    bz = $random(seed);
    engine_busy <= bz;
    rd(16'h0000, 20'h300b0, {2'b00, f, f, 8'h00, ~bz, 1'b0, f, f, 4'h0}, n);
  endtask

  task automatic ea(input logic [4:0] b, input logic e, input string n);
    erase_chk <= 1'b1;
    addr      <= {b, 11'h004};
    rd(16'h0000, 20'h40000, {1'b0, e, 18'h0}, n);
  endtask

  task automatic pin(input logic v);
    wp_pin <= v;
    repeat (6) @(posedge mclk);
  endtask

  // guard against a hang
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    stop_test;
  end

  initial
  begin
    logic [4:0] b;
    logic [4:0] c;
    b = $random(seed);
    c = b + 5'h01;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(16'h0000, 20'h8ffff, 20'h80000, "array after reset");
    id(b, 1'b0, 1'b1, "reset state");
    lk(flk_pkg::CMD_CLR, b);
    st(1'b0, "clear gives status");
    id(b, 1'b0, 1'b0, "clear lock");
    ea(b, 1'b1, "erase open");
    ea(c, 1'b0, "erase shut");
    lk(flk_pkg::CMD_LOCK, b);
    id(b, 1'b0, 1'b1, "set lock");
    cmd1(flk_pkg::CMD_SETUP, {b, 11'h000});
    cmd1(flk_pkg::CMD_CLR, {c, 11'h000});
    cmd1(flk_pkg::CMD_STAT, 16'h0000);
    st(1'b1, "other block error");
    id(c, 1'b0, 1'b1, "error no change");
    lk(flk_pkg::CMD_LOCK, b);
    st(1'b1, "flags sticky");
    cmd1(flk_pkg::CMD_CLRST, 16'h0000);
    cmd1(flk_pkg::CMD_STAT, 16'h0000);
    st(1'b0, "flags cleared");
    cmd1(flk_pkg::CMD_SETUP, {b, 11'h000});
    cmd1(flk_pkg::CMD_ID, {b, 11'h000});
    cmd1(flk_pkg::CMD_STAT, 16'h0000);
    st(1'b1, "bad confirm code");
    cmd1(flk_pkg::CMD_CLRST, 16'h0000);
    lk(flk_pkg::CMD_CLR, c);
    lk(flk_pkg::CMD_LDOWN, c);
    st(1'b0, "lockdown status");
    id(c, 1'b1, 1'b1, "lockdown unlocked blk");
    lk(flk_pkg::CMD_CLR, c);
    st(1'b0, "refused no error");
    id(c, 1'b1, 1'b1, "pin low keeps lock");
    ea(c, 1'b0, "lockdown shut");
    pin(1'b1);
    lk(flk_pkg::CMD_CLR, c);
    id(c, 1'b1, 1'b0, "pin high unlock");
    pin(1'b0);
    id(c, 1'b1, 1'b1, "fall relocks");
    pin(1'b1);
    id(c, 1'b1, 1'b0, "rise from 110");
    lk(flk_pkg::CMD_LOCK, c);
    pin(1'b0);
    pin(1'b1);
    id(c, 1'b1, 1'b1, "rise other prior");
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    id(c, 1'b0, 1'b1, "reset drops lockdown");
    cmd1(flk_pkg::CMD_ARRAY, 16'h0000);
    rd(16'h0000, 20'h8ffff, 20'h80000, "back to array");
    stop_test;
  end
endmodule // test_flk_lock_ctrl
